// ==== logic/io_output_register_path.sv ====
// Purpose: Output path of one pad cell: polarity select, optional output
//          register with load enable and initial value, and drive disable.
// Assumes: Fabric controls come from logic on core_clk; the pad input is
//          asynchronous and is only observed through status.
// Notes: The pad output and enable follow the configuration combinationally
//        in direct mode, as the cell must offer an unregistered path.
//
// Functional notes
// [RQ1] Data optionally inverted, then sent direct or through an edge register.
// [RQ2] Drive disable high puts pad in high impedance regardless of other inputs.
// [RQ3] Data and drive disable polarity each selected independently per cell.
// [RQ4] Power-up or global init forces the register to its configured value.
// [RQ5] Register loads on rising edge while enabled, otherwise holds.
// [RQ6] Unconnected load enable reads as high, loading every edge.
// [RQ7] Unconnected drive disable reads as low, pad stays driven; with CFG_INVERT_DISABLE set the code leaves the pad undriven.
// [RQ8] Load enable shared by input and output registers, selectable, not invertible.
// [RQ9] Polarity selection is applied ahead of the output register.
//
// The strobed register port and the register addresses were left to the implementer.
module io_output_register_path
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic global_init_pulse,

    // Register port
    input wire logic [io_output_register_path_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [io_output_register_path_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [io_output_register_path_pkg::DATA_W-1:0] reg_rdata,

    // Fabric side
    input wire logic out_data,
    input wire logic drive_disable,
    input wire logic load_enable,
    output logic in_load_enable,

    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [io_output_register_path_pkg::CFG_W-1:0] cfg_q;
    logic [io_output_register_path_pkg::CFG_W-1:0] cfg_d;
    logic [io_output_register_path_pkg::DATA_W-1:0] rdata_q;
    logic [io_output_register_path_pkg::DATA_W-1:0] rdata_d;
    logic [io_output_register_path_pkg::STATUS_W-1:0] status;
    logic pad_meta_q;
    logic pad_sync_q;
    logic init_resetn;
    logic reg_clr_q;
    logic reg_clr_d;
    logic reg_set_q;
    logic reg_set_d;
    logic reg_value;
    logic data_pol;
    logic disable_eff;
    logic enable_eff;
    logic out_load;
    logic pad_value;

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_comb
    begin
        cfg_d = cfg_q;
        if (reg_write && reg_addr == io_output_register_path_pkg::CFG_OFFSET)
        begin
            cfg_d = reg_wdata[io_output_register_path_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= io_output_register_path_pkg::CFG_RESET;
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Control defaults, polarity and load enable routing
    // ------------------------------------------------------------
    always_comb
    begin
        enable_eff = io_output_register_path_pkg::ENABLE_DEFAULT; // RQ6
        if (cfg_q[io_output_register_path_pkg::CFG_ENABLE_CONNECTED])
        begin
            enable_eff = load_enable;
        end
        disable_eff = io_output_register_path_pkg::DISABLE_DEFAULT; // RQ7
        if (cfg_q[io_output_register_path_pkg::CFG_DISABLE_CONNECTED])
        begin
            disable_eff = drive_disable;
        end
        // Polarity choices are independent bits of the cell configuration
        disable_eff = disable_eff ^ cfg_q[io_output_register_path_pkg::CFG_INVERT_DISABLE]; // RQ3
        data_pol = out_data ^ cfg_q[io_output_register_path_pkg::CFG_INVERT_DATA]; // RQ3
        // Enable reaches each register only when activated for it, never inverted
        out_load = io_output_register_path_pkg::ENABLE_DEFAULT; // RQ8
        if (cfg_q[io_output_register_path_pkg::CFG_ENABLE_TO_OUTPUT])
        begin
            out_load = enable_eff; // RQ8
        end
        in_load_enable = io_output_register_path_pkg::ENABLE_DEFAULT; // RQ8
        if (cfg_q[io_output_register_path_pkg::CFG_ENABLE_TO_INPUT])
        begin
            in_load_enable = enable_eff; // RQ8
        end
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // Two copies with constant reset levels load the same data, so the
    // configured initial value only selects which copy is seen.
    assign init_resetn = resetn & ~global_init_pulse; // RQ4

    always_comb
    begin
        reg_clr_d = reg_clr_q; // RQ5
        reg_set_d = reg_set_q; // RQ5
        if (out_load)
        begin
            reg_clr_d = data_pol; // RQ9
            reg_set_d = data_pol; // RQ9
        end
    end

    always_ff @(posedge core_clk or negedge init_resetn)
    begin
        if (!init_resetn)
        begin
            reg_clr_q <= io_output_register_path_pkg::REG_CLEAR_LEVEL; // RQ4
        end
        else
        begin
            reg_clr_q <= reg_clr_d; // RQ5
        end
    end

    always_ff @(posedge core_clk or negedge init_resetn)
    begin
        if (!init_resetn)
        begin
            reg_set_q <= io_output_register_path_pkg::REG_SET_LEVEL; // RQ4
        end
        else
        begin
            reg_set_q <= reg_set_d; // RQ5
        end
    end

    assign reg_value = cfg_q[io_output_register_path_pkg::CFG_INIT_VALUE] ?
                       reg_set_q : reg_clr_q; // RQ4

    // ------------------------------------------------------------
    // Pad driver
    // ------------------------------------------------------------
    always_comb
    begin
        pad_value = data_pol; // RQ1
        if (cfg_q[io_output_register_path_pkg::CFG_REGISTERED])
        begin
            pad_value = reg_value; // RQ1
        end
        pad_out = pad_value;
        // Disable overrides clock, enable and data
        pad_oe = ~disable_eff; // RQ2
    end

    // ------------------------------------------------------------
    // Pad input synchroniser for status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pad_meta_q <= io_output_register_path_pkg::SYNC_RESET_LEVEL;
            pad_sync_q <= io_output_register_path_pkg::SYNC_RESET_LEVEL;
        end
        else
        begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        status = '0;
        status[io_output_register_path_pkg::ST_REG_VALUE] = reg_value;
        status[io_output_register_path_pkg::ST_PAD_DRIVEN] = ~disable_eff;
        status[io_output_register_path_pkg::ST_PAD_OUT] = pad_value;
        status[io_output_register_path_pkg::ST_PAD_IN] = pad_sync_q;
        rdata_d = io_output_register_path_pkg::READ_ZERO;
        if (reg_read)
        begin
            case (reg_addr)
                io_output_register_path_pkg::CFG_OFFSET:
                begin
                    rdata_d[io_output_register_path_pkg::CFG_W-1:0] = cfg_q;
                end
                io_output_register_path_pkg::STATUS_OFFSET:
                begin
                    rdata_d[io_output_register_path_pkg::STATUS_W-1:0] = status;
                end
                default:
                begin
                    rdata_d = io_output_register_path_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= io_output_register_path_pkg::READ_ZERO;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// ==== logic/io_output_register_path_pkg.sv ====
// Purpose: Shared constants for the pad cell output register path.
// Assumes: 32-bit register port, word-aligned offsets.
// Notes: Configuration bit positions and reset values live here; the assertions and testbench repeat them as literals.
package io_output_register_path_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_W = 8;
    localparam int unsigned CFG_REGISTERED = 0;
    localparam int unsigned CFG_INVERT_DATA = 1;
    localparam int unsigned CFG_INVERT_DISABLE = 2;
    localparam int unsigned CFG_INIT_VALUE = 3;
    localparam int unsigned CFG_ENABLE_CONNECTED = 4;
    localparam int unsigned CFG_DISABLE_CONNECTED = 5;
    localparam int unsigned CFG_ENABLE_TO_OUTPUT = 6;
    localparam int unsigned CFG_ENABLE_TO_INPUT = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int unsigned STATUS_W = 4;
    localparam int unsigned ST_REG_VALUE = 0;
    localparam int unsigned ST_PAD_DRIVEN = 1;
    localparam int unsigned ST_PAD_OUT = 2;
    localparam int unsigned ST_PAD_IN = 3;

    // ------------------------------------------------------------
    // Defaults of unconnected controls and register reset levels
    // ------------------------------------------------------------
    localparam logic ENABLE_DEFAULT = 1'h1;
    localparam logic DISABLE_DEFAULT = 1'h0;
    localparam logic REG_CLEAR_LEVEL = 1'h0;
    localparam logic REG_SET_LEVEL = 1'h1;
    localparam logic SYNC_RESET_LEVEL = 1'h0;

endpackage

// ==== dv/io_output_register_path_sva.sv ====
// Purpose: Port assertions for the pad cell output path.
// Assumes: Configuration is shadowed from register port writes.
// Notes: Bound to every instance of the design.
module io_output_register_path_sva
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic global_init_pulse,
    // Register port
    input wire logic [io_output_register_path_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [io_output_register_path_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [io_output_register_path_pkg::DATA_W-1:0] reg_rdata,
    // Fabric and pad
    input wire logic out_data,
    input wire logic drive_disable,
    input wire logic load_enable,
    input wire logic in_load_enable,
    input wire logic pad_in,
    input wire logic pad_out,
    input wire logic pad_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic ld;
    logic dd;
    logic quiet;
    assign cfg_d = (reg_write && reg_addr == 8'h00) ? reg_wdata[7:0] : cfg_q;
    assign ld = !cfg_q[6] || !cfg_q[4] || load_enable;
    assign dd = out_data ^ cfg_q[1];
    assign quiet = cfg_q[0] && !global_init_pulse && !reg_write;
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
            cfg_q <= 8'h00;
        else
            cfg_q <= cfg_d;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_read_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_drive_off: assert property (pad_oe == !((cfg_q[5] && drive_disable) ^ cfg_q[2]))
        else $error("pad enable wrong");
    a_direct_data: assert property (!cfg_q[0] |-> pad_out == dd)
        else $error("direct pad value wrong");
    a_reg_load: assert property (quiet && ld |=> global_init_pulse || pad_out == $past(dd))
        else $error("register did not load");
    a_reg_hold: assert property (quiet && !ld |=> global_init_pulse || $stable(pad_out))
        else $error("register did not hold");
    a_init_force: assert property (global_init_pulse && cfg_q[0] |-> pad_out == cfg_q[3])
        else $error("register not at init value");
    a_open_enable: assert property (quiet && cfg_q[6] && !cfg_q[4] |=> global_init_pulse
        || pad_out == $past(dd))
        else $error("open load enable did not load");
    a_in_enable: assert property (in_load_enable == (!cfg_q[7] || !cfg_q[4] || load_enable))
        else $error("input register enable wrong");
    cover property (quiet && !ld);
    cover property (quiet && ld && cfg_q[6]);
    cover property (global_init_pulse && cfg_q[0]);
    cover property (!pad_oe);
endmodule
bind io_output_register_path io_output_register_path_sva u_sva (.core_clk, .resetn,
    .global_init_pulse, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .out_data,
    .drive_disable, .load_enable, .in_load_enable, .pad_in, .pad_out, .pad_oe);

// ==== dv/pad_board_model.sv ====
// Purpose: Board net on the pad.
// Assumes: Net has a pull-up; a board driver may take it.
// Notes: Board driver only drives while the cell is off.
module pad_board_model
(
    // Pad cell
    input wire logic pad_out,
    input wire logic pad_oe,
    // Board driver
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pad_in = pad_oe ? pad_out : (ext_en ? ext_val : 1'h1);
endmodule

// ==== dv/tb_io_output_register_path.sv ====
// Purpose: Directed tests of the pad cell output path.
// Assumes: 50 MHz clock, reset held 10 cycles.
// Notes: Pins compared as the pair {pad_oe, pad_out}.
module tb_io_output_register_path;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0, resetn = 1'h0, global_init_pulse = 1'h0, reg_write = 1'h0;
    logic reg_read = 1'h0, out_data = 1'h1, drive_disable = 1'h0, load_enable = 1'h0;
    logic ext_en = 1'h0, ext_val = 1'h0, in_load_enable, pad_in, pad_out, pad_oe;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    int err_count = 0;
    int check_count = 0;
    io_output_register_path DUT (.core_clk, .resetn, .global_init_pulse, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .out_data, .drive_disable,
        .load_enable, .in_load_enable, .pad_in, .pad_out, .pad_oe);
    pad_board_model board (.pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge core_clk);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge core_clk);
        reg_read <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pins(input logic oe, input logic o);
        chk("pins", 32'({pad_oe, pad_out}), 32'({oe, o}));
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100us;
        err_count++;
        results();
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        step(3);
        rd(8'h00);
        chk("cfg", v, 32'h0);
        rd(8'h04);
        chk("status", v & 32'hFFFF_FFFE, 32'hE);
        wr(8'h08, 32'hFF);
        rd(8'h08);
        chk("unmapped", v, 32'h0);
        rd(8'h00);
        chk("cfg", v, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h00, 32'h20 | 32'(i & 6));
            drive_disable <= i[0];
            out_data <= i[0];
            step(1);
            pins(~(i[0] ^ i[2]), i[0] ^ i[1]);
        end
        wr(8'h00, 32'h04);
        out_data <= 1'h1;
        step(3);
        rd(8'h04);
        chk("status", v & 32'hFFFF_FFFE, 32'hC);
        @(posedge core_clk);
        ext_en <= 1'h1;
        step(3);
        rd(8'h04);
        chk("status", v & 32'hFFFF_FFFE, 32'h4);
        // Register is cleared first so that the registered load is visible
        @(posedge core_clk);
        ext_en <= 1'h0;
        out_data <= 1'h0;
        $display("test polarity done");
        wr(8'h00, 32'h53);
        load_enable <= 1'h1;
        step(1);
        pins(1'h1, 1'h1);
        @(posedge core_clk);
        load_enable <= 1'h0;
        out_data <= 1'h1;
        step(2);
        pins(1'h1, 1'h1);
        wr(8'h00, 32'h41);
        out_data <= 1'h0;
        step(1);
        pins(1'h1, 1'h0);
        wr(8'h00, 32'h91);
        out_data <= 1'h1;
        step(1);
        chk("in enable", 32'(in_load_enable), 32'h0);
        step(1);
        pins(1'h1, 1'h1);
        $display("test register done");
        for (int b = 0; b < 2; b++)
        begin
            wr(8'h00, 32'h41 | 32'(b << 3));
            out_data <= b[0];
            @(posedge core_clk);
            out_data <= ~b[0];
            global_init_pulse <= 1'h1;
            step(2);
            pins(1'h1, b[0]);
            @(posedge core_clk);
            global_init_pulse <= 1'h0;
            step(1);
            pins(1'h1, ~b[0]);
        end
        @(posedge core_clk);
        resetn <= 1'h0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'h1;
        rd(8'h00);
        chk("cfg", v, 32'h0);
        rd(8'h04);
        chk("status", v, 32'h2);
        $display("test init done");
        results();
    end
endmodule
